//--- hdl/umds_core.sv
/*
 * umds_core: special character detect, normal and automatic multidrop
 * filtering, infrared encode/decode, sleep with wake-up and power-save.
 * assumes: framing, fifos and register map sit outside; received characters
 * arrive as a one-cycle strobe with data and parity bit; tx bit stream and
 * a 16x sample tick come from the baud generator on this clock.
 */
// Operation
// [RULE_01] special enable compares, still stores match
// [RULE_02] match sets special flag in status
// [RULE_03] compare only configured word length bits
// [RULE_04] normal multidrop: mdrop bit, unlock, no special
// [RULE_05] host forces parity zero for addresses; the core takes parity one as address
// [RULE_06] disabled: drop data, flag address, store
// [RULE_07] enabled: accept data, interrupt on address
// [RULE_08] host enables receiver on own address
// [RULE_09] auto address: mdrop and special set
// [RULE_10] auto: discard until matching address
// [RULE_11] match enables receiver, stores, interrupts
// [RULE_12] receiving: mismatch disables, match stored
// [RULE_13] infrared enable, 3/16 high pulse per zero
// [RULE_14] irda 1.1 uses quarter-bit pulse
// [RULE_15] infrared rx idles low, pulses decoded
// [RULE_16] sleep only when idle, enabled, quiet
// [RULE_17] wake on start, tx write, modem change
// [RULE_18] return to sleep once serviced
// [RULE_19] cycle sleep until enable cleared
// [RULE_20] power-save isolates host bus when asleep
// [RULE_21] power-save wakes only on rx, modem
// [RULE_22] wake interrupt enable, off after reset
// [RULE_23] wake interrupt held until status read
`timescale 1ns/1ns
`include "umds_consts.svh"

module umds_core
    import umds_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // configuration
    input  wire logic [7:0] enhanced_feature_reg_i,
    input  wire logic [7:0] modem_status_wr_i,
    input  wire logic [7:0] modem_control_reg_i,
    input  wire logic [7:0] interrupt_enable_reg_i,
    input  wire logic [7:0] fifo_control_reg_i,
    input  wire logic [1:0] word_length_i,
    input  wire logic [7:0] slave_address_char_i,
    input  wire logic       rx_enable_sw_i,
    input  wire logic       rx_disable_sw_i,
    // receiver character strobe
    input  wire logic       char_valid_i,
    input  wire logic [7:0] char_data_i,
    input  wire logic       char_parity_i,
    output logic            fifo_valid_o,
    input  wire logic       fifo_ready_i,
    output umds_char_t      fifo_data_o,
    output logic            special_flag_o,
    input  wire logic       isr_read_i,
    output logic            line_status_irq_o,
    output logic            rx_enabled_o,
    // serial line
    input  wire logic       rx_pin_i,
    output logic            rx_serial_o,
    input  wire logic       tx_bit_i,
    input  wire logic       tick16_i,
    output logic            tx_pin_o,
    // sleep
    input  wire logic       irq_pending_i,
    input  wire logic       modem_delta_i,
    input  wire logic [3:0] modem_in_i,
    input  wire logic       divisor_zero_i,
    input  wire logic       fifos_empty_i,
    input  wire logic       thr_write_i,
    input  wire logic       power_save_pin_i,
    input  wire logic       bus_strobe_i,
    output logic            bus_strobe_o,
    output logic            sleeping_o,
    output logic            wake_irq_o
);

    typedef struct packed {
        logic [1:0] rx_sync;
        logic [1:0] ps_sync;
        logic [3:0] mdm_s1;
        logic [3:0] mdm_s2;
        logic [3:0] mdm_prev;
        logic       rx_prev;
        logic       rx_en;
        logic       special;
        logic       ls_irq;
        logic [3:0] tick;
        logic       tx_out;
        logic       rx_dec;
        umds_pwr_t  pwr;
        logic       wake_irq;
        logic       bus_strobe;
    } umds_st_t;

    umds_st_t   st;
    umds_st_t   next_st;
    logic       in_valid;
    logic       in_ready;
    umds_char_t in_data;

    function automatic logic [7:0] wl_mask(input logic [1:0] wl);
        wl_mask = 8'hff >> (3'd3 - {1'b0, wl});
    endfunction

    logic unlock;
    logic special_en;
    logic mdrop_norm;
    logic mdrop_auto;
    logic ir_en;
    logic ir11;
    logic match;
    logic is_addr;
    logic rx_idle;
    logic rx_fall;
    logic mdm_change;
    logic sleep_ok;
    logic [3:0] width;

    always_comb begin
        unlock     = enhanced_feature_reg_i[`UMDS_EFR_UNLOCK_BIT];
        special_en = enhanced_feature_reg_i[`UMDS_EFR_SPECIAL_BIT];
        // [RULE_04] normal multidrop select
        mdrop_norm = modem_status_wr_i[`UMDS_MSRW_MDROP_BIT] && unlock && !special_en;
        // [RULE_09] auto address select
        mdrop_auto = modem_status_wr_i[`UMDS_MSRW_MDROP_BIT] && unlock && special_en;
        ir_en      = modem_control_reg_i[`UMDS_MCR_IR_BIT];
        ir11       = modem_status_wr_i[`UMDS_MSRW_IRDA11_BIT] && unlock;
        // [RULE_03] word length compare
        match      = ((char_data_i ^ slave_address_char_i) & wl_mask(word_length_i)) == 8'h00;
        is_addr    = char_parity_i;
        // [RULE_15] idle level per mode
        rx_idle    = ir_en ? !st.rx_sync[1] : st.rx_sync[1];
        rx_fall    = ir_en ? (st.rx_sync[1] && !st.rx_prev) : (!st.rx_sync[1] && st.rx_prev);
        mdm_change = st.mdm_s2 != st.mdm_prev;
        // [RULE_16] sleep entry conditions
        sleep_ok   = !irq_pending_i && interrupt_enable_reg_i[`UMDS_IER_SLEEP_BIT]
                     && !modem_delta_i && rx_idle && !divisor_zero_i && fifos_empty_i
                     && !st.wake_irq && !st.ls_irq && !st.special;
        // [RULE_14] pulse width select
        width      = ir11 ? `UMDS_IR11_SIXTEENTHS : `UMDS_IR10_SIXTEENTHS;
    end

    // ==========================================
    // receive filtering
    always_comb begin
        next_st       = st;
        in_valid      = 1'b0;
        in_data       = '0;
        in_data.data  = char_data_i;
        in_data.parity_tag = char_parity_i;
        in_data.special    = special_en && match;
        next_st.rx_sync = {st.rx_sync[0], rx_pin_i};
        next_st.ps_sync = {st.ps_sync[0], power_save_pin_i};
        next_st.mdm_s1  = modem_in_i;
        next_st.mdm_s2  = st.mdm_s1;
        next_st.mdm_prev = st.mdm_s2;
        next_st.rx_prev = st.rx_sync[1];
        if (rx_enable_sw_i) begin
            next_st.rx_en = 1'b1;
        end else if (rx_disable_sw_i) begin
            next_st.rx_en = 1'b0;
        end
        if (isr_read_i) begin
            next_st.special  = 1'b0;
            next_st.ls_irq   = 1'b0;
            next_st.wake_irq = 1'b0;
        end
        if (char_valid_i) begin
            if (mdrop_auto) begin
                // [RULE_10] discard until address match
                if (is_addr && match) begin
                    // [RULE_11] enable, store, interrupt
                    next_st.rx_en  = 1'b1;
                    in_valid       = 1'b1;
                    next_st.ls_irq = 1'b1;
                end else if (is_addr) begin
                    // [RULE_12] mismatch disables receiver
                    next_st.rx_en = 1'b0;
                end else begin
                    in_valid = st.rx_en;
                end
            end else if (mdrop_norm) begin
                // [RULE_06] address flagged and stored
                if (is_addr) begin
                    in_valid       = 1'b1;
                    // [RULE_07] interrupt on every address
                    next_st.ls_irq = 1'b1;
                end else begin
                    in_valid = st.rx_en;
                end
            end else begin
                // [RULE_01] match still stored
                in_valid = 1'b1;
                if (special_en && match) begin
                    // [RULE_02] special flag set wins
                    next_st.special = 1'b1;
                end
            end
        end
        // infrared encoder
        if (tick16_i) begin
            next_st.tick = st.tick + 4'h1;
        end
        // [RULE_13] high pulse for zero bits
        next_st.tx_out = ir_en ? (!tx_bit_i && st.tick < width) : tx_bit_i;
        // [RULE_15] light pulse returns zero bit
        next_st.rx_dec = ir_en ? !st.rx_sync[1] : st.rx_sync[1];
        // sleep control
        case (st.pwr)
            UMDS_AWAKE: begin
                // [RULE_19] re-enter while enabled
                if (sleep_ok && !char_valid_i && !thr_write_i) begin
                    next_st.pwr = UMDS_ASLEEP;
                end
            end
            UMDS_ASLEEP: begin
                // [RULE_17] wake events
                // [RULE_21] power-save wake sources
                if (rx_fall || mdm_change || (thr_write_i && !st.ps_sync[1])
                    || !interrupt_enable_reg_i[`UMDS_IER_SLEEP_BIT]) begin
                    next_st.pwr = UMDS_AWAKE;
                    // [RULE_23] wake interrupt
                    if (fifo_control_reg_i[`UMDS_FCR_WAKE_BIT]) begin
                        next_st.wake_irq = 1'b1;
                    end
                end
            end
            default: next_st.pwr = UMDS_AWAKE;
        endcase
        // [RULE_22] wake interrupt gated by enable
        if (!fifo_control_reg_i[`UMDS_FCR_WAKE_BIT]) begin
            next_st.wake_irq = 1'b0;
        end
        // [RULE_20] isolate bus strobes
        next_st.bus_strobe = bus_strobe_i && !(st.ps_sync[1] && st.pwr == UMDS_ASLEEP);
    end

    // [RULE_18] automatic return via sleep_ok
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st          <= '0;
            st.rx_sync  <= 2'b11;
            st.rx_prev  <= 1'b1;
            st.tx_out   <= 1'b1;
            st.rx_dec   <= 1'b1;
            st.pwr      <= UMDS_AWAKE;
        end else begin
            st <= next_st;
        end
    end

    umds_buf u_buf (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (in_valid),
        .in_ready_o  (in_ready),
        .in_data_i   (in_data),
        .out_valid_o (fifo_valid_o),
        .out_ready_i (fifo_ready_i),
        .out_data_o  (fifo_data_o)
    );

    assign special_flag_o    = st.special;
    assign line_status_irq_o = st.ls_irq;
    assign rx_enabled_o      = st.rx_en;
    assign rx_serial_o       = st.rx_dec;
    assign tx_pin_o          = st.tx_out;
    assign sleeping_o        = st.pwr == UMDS_ASLEEP;
    assign wake_irq_o        = st.wake_irq;
    assign bus_strobe_o      = st.bus_strobe;

    // ==========================================
    // assertions
    property p_special;
        @(posedge clk_i) disable iff (srst_i)
        (char_valid_i && special_en && !mdrop_auto && !mdrop_norm && match) |=> st.special;
    endproperty
    a_special: assert property (p_special) else $error("special flag missed"); // [RULE_02]

    property p_auto_drop;
        @(posedge clk_i) disable iff (srst_i)
        (char_valid_i && mdrop_auto && is_addr && !match) |=> !st.rx_en || $past(rx_enable_sw_i);
    endproperty
    a_auto_drop: assert property (p_auto_drop) else $error("mismatch kept rx on"); // [RULE_12]

    property p_auto_match;
        @(posedge clk_i) disable iff (srst_i)
        (char_valid_i && mdrop_auto && is_addr && match) |=> st.ls_irq && st.rx_en;
    endproperty
    a_auto_match: assert property (p_auto_match) else $error("match not taken"); // [RULE_11]

    property p_norm_irq;
        @(posedge clk_i) disable iff (srst_i)
        (char_valid_i && mdrop_norm && is_addr) |=> st.ls_irq;
    endproperty
    a_norm_irq: assert property (p_norm_irq) else $error("address no irq"); // [RULE_06]

    property p_no_sleep_irq;
        @(posedge clk_i) disable iff (srst_i)
        (st.pwr == UMDS_AWAKE && irq_pending_i) |=> st.pwr == UMDS_AWAKE;
    endproperty
    a_no_sleep_irq: assert property (p_no_sleep_irq) else $error("slept with irq"); // [RULE_16]

    property p_wake;
        @(posedge clk_i) disable iff (srst_i)
        (st.pwr == UMDS_ASLEEP && mdm_change) |=> st.pwr == UMDS_AWAKE;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on modem change"); // [RULE_17]

    property p_isolate;
        @(posedge clk_i) disable iff (srst_i)
        (st.ps_sync[1] && st.pwr == UMDS_ASLEEP) |=> !st.bus_strobe;
    endproperty
    a_isolate: assert property (p_isolate) else $error("bus not isolated"); // [RULE_20]

    property p_wake_off;
        @(posedge clk_i) disable iff (srst_i)
        !fifo_control_reg_i[`UMDS_FCR_WAKE_BIT] |=> !st.wake_irq;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("wake irq while disabled"); // [RULE_22]

    property p_no_loss;
        @(posedge clk_i) disable iff (srst_i)
        in_valid |-> in_ready;
    endproperty
    a_no_loss: assert property (p_no_loss) else $error("stored character lost"); // [RULE_01]

    c_sleep: cover property (@(posedge clk_i) st.pwr == UMDS_ASLEEP);
    c_auto: cover property (@(posedge clk_i) char_valid_i && mdrop_auto && match);
    c_wake: cover property (@(posedge clk_i) st.wake_irq);

endmodule // umds_core

//--- hdl/umds_consts.svh
/*
 * umds constants: bit positions, reset values and timing counts for the
 * multidrop, special character, infrared and sleep block.
 * assumes: included by bare name from the design files.
 */
`ifndef UMDS_CONSTS_SVH
`define UMDS_CONSTS_SVH

// ==========================================
// register bit positions
`define UMDS_EFR_UNLOCK_BIT   4
`define UMDS_EFR_SPECIAL_BIT  5
`define UMDS_MSRW_MDROP_BIT   6
`define UMDS_MSRW_IRDA11_BIT  7
`define UMDS_MCR_IR_BIT       6
`define UMDS_IER_SLEEP_BIT    4
`define UMDS_FCR_WAKE_BIT     3
`define UMDS_ISR_SPECIAL_BIT  4

// ==========================================
// infrared pulse widths in sixteenths of a bit
`define UMDS_IR10_SIXTEENTHS  4'h3
`define UMDS_IR11_SIXTEENTHS  4'h4

// ==========================================
// reset values
`define UMDS_RST_BYTE         8'h00
`define UMDS_RST_TICK         4'h0

`endif

//--- hdl/umds_pkg.sv
/*
 * umds package: types shared by the block and its output buffer.
 * assumes: nothing beyond the constants header.
 */
package umds_pkg;

    // ==========================================
    // received character with its tags
    typedef struct packed {
        logic [7:0] data;
        logic       parity_tag;
        logic       special;
    } umds_char_t;

    // ==========================================
    // power states
    typedef enum logic [1:0] {
        UMDS_AWAKE  = 2'b00,
        UMDS_ASLEEP = 2'b01
    } umds_pwr_t;

endpackage

//--- hdl/umds_buf.sv
/*
 * umds_buf: two-entry valid/ready buffer for received characters.
 * assumes: single clock, synchronous reset.
 */
`timescale 1ns/1ns
`include "umds_consts.svh"

module umds_buf
    import umds_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       in_valid_i,
    output logic            in_ready_o,
    input  umds_char_t      in_data_i,
    output logic            out_valid_o,
    input  wire logic       out_ready_i,
    output umds_char_t      out_data_o
);

    typedef struct packed {
        umds_char_t  [1:0] mem;
        logic        [1:0] cnt;
        logic              rd;
    } umds_buf_st_t;

    umds_buf_st_t st;
    umds_buf_st_t next_st;
    logic         push;
    logic         pop;

    // ==========================================
    // pointer and count update
    always_comb begin
        next_st = st;
        push    = in_valid_i && ((st.cnt != 2'd2) || out_ready_i);
        pop     = (st.cnt != 2'd0) && out_ready_i;
        if (push) begin
            next_st.mem[st.rd ^ st.cnt[0]] = in_data_i;
        end
        if (pop) begin
            next_st.rd = ~st.rd;
        end
        next_st.cnt = 2'(st.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_o  = (st.cnt != 2'd2) || out_ready_i;
    assign out_valid_o = (st.cnt != 2'd0);
    assign out_data_o  = st.mem[st.rd];

    property p_buf_range;
        @(posedge clk_i) disable iff (srst_i)
        st.cnt != 2'd3;
    endproperty
    a_buf_range: assert property (p_buf_range) else $error("buffer count out of range");

    property p_buf_hold;
        @(posedge clk_i) disable iff (srst_i)
        (st.cnt == 2'd2 && !out_ready_i) |=> st.cnt == 2'd2;
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("full buffer lost a word");

endmodule // umds_buf

//--- bench/umds_remote.sv
/*
 * umds_remote: far serial node or infrared transceiver on the rx and tx pins.
 * assumes: same clock as the block; requests are one-cycle pulses.
 */
`timescale 1ns/1ns

module umds_remote (
    input  wire logic       clk_i,
    input  wire logic       ir_mode_i,
    input  wire logic       start_i,
    input  wire logic       cnt_en_i,
    input  wire logic       cnt_clr_i,
    input  wire logic       tx_pin_i,
    output logic            rx_pin_o,
    output logic [7:0]      high_cnt_o
);
    // ==========================================
    // line driver: start bit low, light pulse high
    int left = 0;
    always @(posedge clk_i) begin
        if (start_i)
            left <= ir_mode_i ? 3 : 16;
        else if (left > 0)
            left <= left - 1;
    end
    assign rx_pin_o = (left > 0) ? ir_mode_i : !ir_mode_i;

    // ==========================================
    // pulse width meter on the tx pin
    initial high_cnt_o = 8'h00;
    always @(posedge clk_i) begin
        if (cnt_clr_i)
            high_cnt_o <= 8'h00;
        else if (cnt_en_i && tx_pin_i)
            high_cnt_o <= high_cnt_o + 8'h01;
    end
endmodule // umds_remote

//--- bench/tb_uart_multidrop_irda_sleep.sv
/*
 * tb_uart_multidrop_irda_sleep: self-checking bench for umds_core.
 * assumes: design files compiled first; inputs change 1 ns after clk_i rises.
 */
`timescale 1ns/1ns

module tb_uart_multidrop_irda_sleep;
    import umds_pkg::*;
    logic clk_i = 0, srst_i = 1;
    logic [7:0] enhanced_feature_reg_i = 8'h00, modem_status_wr_i = 8'h00;
    logic [7:0] modem_control_reg_i = 8'h00, interrupt_enable_reg_i = 8'h00;
    logic [7:0] fifo_control_reg_i = 8'h00, slave_address_char_i = 8'h00;
    logic [7:0] char_data_i = 8'h00, high_cnt_o;
    logic [1:0] word_length_i = 2'h3;
    logic [3:0] modem_in_i = 4'h0;
    logic rx_enable_sw_i = 0, rx_disable_sw_i = 0, char_valid_i = 0, char_parity_i = 0;
    logic fifo_ready_i = 0, isr_read_i = 0, tx_bit_i = 1, tick16_i = 1, irq_pending_i = 0;
    logic modem_delta_i = 0, divisor_zero_i = 0, fifos_empty_i = 1, thr_write_i = 0;
    logic power_save_pin_i = 0, bus_strobe_i = 0, start_i = 0, cnt_en_i = 0, cnt_clr_i = 0;
    logic fifo_valid_o, special_flag_o, line_status_irq_o, rx_enabled_o, rx_pin_i;
    logic rx_serial_o, tx_pin_o, bus_strobe_o, sleeping_o, wake_irq_o, seen;
    umds_char_t fifo_data_o;
    int checks = 0, fail_count = 0;

    initial forever #4 clk_i = ~clk_i;

    umds_core u_umds_core (.clk_i, .srst_i, .enhanced_feature_reg_i, .modem_status_wr_i,
        .modem_control_reg_i, .interrupt_enable_reg_i, .fifo_control_reg_i, .word_length_i,
        .slave_address_char_i, .rx_enable_sw_i, .rx_disable_sw_i, .char_valid_i,
        .char_data_i, .char_parity_i, .fifo_valid_o, .fifo_ready_i, .fifo_data_o,
        .special_flag_o, .isr_read_i, .line_status_irq_o, .rx_enabled_o, .rx_pin_i,
        .rx_serial_o, .tx_bit_i, .tick16_i, .tx_pin_o, .irq_pending_i, .modem_delta_i,
        .modem_in_i, .divisor_zero_i, .fifos_empty_i, .thr_write_i, .power_save_pin_i,
        .bus_strobe_i, .bus_strobe_o, .sleeping_o, .wake_irq_o);

    umds_remote u_umds_remote (.clk_i, .ir_mode_i(modem_control_reg_i[6]), .start_i,
        .cnt_en_i, .cnt_clr_i, .tx_pin_i(tx_pin_o), .rx_pin_o(rx_pin_i), .high_cnt_o);

    // ==========================================
    // access and compare tasks
    task automatic step(int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic tally(logic [8:0] got, logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(logic got, logic exp);
        tally({8'h00, got}, {8'h00, exp});
    endtask
    task automatic chk_char(logic [8:0] got, logic [8:0] exp);
        tally(got, exp);
    endtask
    task automatic chk_cnt(logic [7:0] got, logic [7:0] exp);
        tally({1'b0, got}, {1'b0, exp});
    endtask
    task automatic put(logic [7:0] d, logic p);
        char_data_i = d;
        char_parity_i = p;
        char_valid_i = 1;
        step();
        char_valid_i = 0;
        step();
    endtask
    task automatic pop(logic [7:0] d, logic p);
        chk_bit(fifo_valid_o, 1);
        chk_char({fifo_data_o.data, fifo_data_o.parity_tag}, {d, p});
        fifo_ready_i = 1;
        step();
        fifo_ready_i = 0;
    endtask
    task automatic ack();
        isr_read_i = 1;
        step();
        isr_read_i = 0;
        step();
    endtask
    task automatic sw(logic en);
        rx_enable_sw_i = en;
        rx_disable_sw_i = !en;
        step();
        rx_enable_sw_i = 0;
        rx_disable_sw_i = 0;
        step();
    endtask
    task automatic measure(logic [7:0] exp);
        cnt_clr_i = 1;
        step();
        cnt_clr_i = 0;
        cnt_en_i = 1;
        step(32);
        cnt_en_i = 0;
        chk_cnt(high_cnt_o, exp);
    endtask
    task automatic wait_slp(logic e);
        for (int i = 0; i < 40 && sleeping_o !== e; i++) step();
        chk_bit(sleeping_o, e);
        if (sleeping_o !== e) stop_test();
    endtask
    task automatic stop_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================
    // test sequence
    initial begin
        step(8);
        srst_i = 0;
        chk_bit(wake_irq_o, 0);          // wake off
        chk_bit(tx_pin_o, 1);            // idle mark
        enhanced_feature_reg_i = 8'h20;
        word_length_i = 2'h0;
        slave_address_char_i = 8'hD5;
        put(8'h35, 0);
        chk_bit(special_flag_o, 1);      // flag set
        chk_bit(fifo_data_o.special, 1); // tagged match
        pop(8'h35, 0);                   // still stored
        ack();
        put(8'h36, 0);
        chk_bit(special_flag_o, 0);      // low bits differ
        pop(8'h36, 0);                   // normal data
        word_length_i = 2'h3;
        put(8'h35, 0);
        chk_bit(special_flag_o, 0);      // full width
        pop(8'h35, 0);                   // normal data
        $display("test special done");
        enhanced_feature_reg_i = 8'h10;
        modem_status_wr_i = 8'h40;
        step();
        put(8'h11, 0);
        chk_bit(fifo_valid_o, 0);        // data dropped
        put(8'h2A, 1);                   // parity one marks address
        chk_bit(line_status_irq_o, 1);   // address irq
        pop(8'h2A, 1);                   // stored flagged
        ack();
        sw(1);                           // host enables
        chk_bit(rx_enabled_o, 1);        // receiver on
        put(8'h12, 0);
        chk_bit(line_status_irq_o, 0);   // data quiet
        pop(8'h12, 0);                   // data accepted
        put(8'h2B, 1);
        chk_bit(line_status_irq_o, 1);   // address irq
        pop(8'h2B, 1);                   // address stored
        ack();
        sw(0);                           // host disables
        $display("test multidrop done");
        enhanced_feature_reg_i = 8'h30;
        slave_address_char_i = 8'h42;    // slave address
        step();
        put(8'h42, 0);
        chk_bit(fifo_valid_o, 0);        // data discarded
        put(8'h41, 1);
        chk_bit(fifo_valid_o, 0);        // other address
        chk_bit(line_status_irq_o, 0);   // no irq
        chk_bit(rx_enabled_o, 0);        // still off
        put(8'h42, 1);
        chk_bit(rx_enabled_o, 1);        // auto enable
        chk_bit(line_status_irq_o, 1);   // irq raised
        put(8'h07, 0);
        pop(8'h42, 1);                   // stored with parity
        pop(8'h07, 0);                   // then data
        ack();
        put(8'h42, 1);
        pop(8'h42, 1);                   // match kept
        put(8'h43, 1);
        chk_bit(rx_enabled_o, 0);        // auto disable
        put(8'h08, 0);
        chk_bit(fifo_valid_o, 0);        // dropped
        ack();
        $display("test auto address done");
        enhanced_feature_reg_i = 8'h00;
        modem_status_wr_i = 8'h00;
        modem_control_reg_i = 8'h40;
        step(20);
        chk_bit(rx_serial_o, 1);         // dark is idle
        start_i = 1;
        step();
        start_i = 0;
        seen = 0;
        for (int i = 0; i < 8; i++) begin
            step();
            seen = seen | (rx_serial_o === 1'b0);
        end
        chk_bit(seen, 1);                // light decoded
        measure(8'h00);                  // ones send no light
        tx_bit_i = 0;
        step(20);
        measure(8'h06);                  // three sixteenths
        enhanced_feature_reg_i = 8'h10;
        modem_status_wr_i = 8'h80;
        step(20);
        measure(8'h08);                  // quarter bit
        modem_control_reg_i = 8'h00;
        modem_status_wr_i = 8'h00;
        tx_bit_i = 1;
        $display("test infrared done");
        step(20);
        chk_bit(sleeping_o, 0);          // enable clear
        irq_pending_i = 1;
        interrupt_enable_reg_i = 8'h10;
        step(20);
        chk_bit(sleeping_o, 0);          // pending blocks
        irq_pending_i = 0;
        divisor_zero_i = 1;
        step(20);
        chk_bit(sleeping_o, 0);          // zero divisor blocks
        divisor_zero_i = 0;
        modem_delta_i = 1;
        step(20);
        chk_bit(sleeping_o, 0);          // latched change blocks
        modem_delta_i = 0;
        wait_slp(1);                     // sleeps
        fifos_empty_i = 0;
        thr_write_i = 1;
        step();
        thr_write_i = 0;
        wait_slp(0);                     // tx write wakes
        chk_bit(wake_irq_o, 0);          // default off
        fifos_empty_i = 1;
        wait_slp(1);                     // back asleep
        fifo_control_reg_i = 8'h08;
        modem_in_i = 4'h1;
        wait_slp(0);                     // modem wakes
        step(3);
        chk_bit(wake_irq_o, 1);          // held
        chk_bit(sleeping_o, 0);          // pending wake blocks
        ack();
        chk_bit(wake_irq_o, 0);          // cleared by read
        fifo_control_reg_i = 8'h00;
        wait_slp(1);                     // cycles back
        power_save_pin_i = 1;
        bus_strobe_i = 1;
        step(5);
        chk_bit(bus_strobe_o, 0);        // bus isolated
        thr_write_i = 1;
        step();
        thr_write_i = 0;
        step(5);
        chk_bit(sleeping_o, 1);          // bus write ignored
        start_i = 1;
        step();
        start_i = 0;
        wait_slp(0);                     // start bit wakes
        step(2);
        chk_bit(bus_strobe_o, 1);        // bus live awake
        wait_slp(1);                     // re-enters
        modem_in_i = 4'h3;
        wait_slp(0);                     // modem wakes
        $display("test sleep done");
        stop_test();
    end
endmodule // tb_uart_multidrop_irda_sleep
